/* pkg/lwf_pkg.sv */
/*
 * Shared constants and types for the lane-width fallback and turnoff
 * handshake: lane counts, width codes, speed codes, state codes.
 * Assumes both ends are clocked by one 125 MHz clock.
 */
`default_nettype none
package lwf_pkg;
    localparam int unsigned LANES_MAX = 8;
    // width codes: one-hot lane counts
    localparam logic [3:0] WID_X1 = 4'h1;
    localparam logic [3:0] WID_X2 = 4'h2;
    localparam logic [3:0] WID_X4 = 4'h4;
    localparam logic [3:0] WID_X8 = 4'h8;
    localparam logic [3:0] WID_NONE = 4'h0;
    // speed codes
    localparam logic [1:0] SPD_GEN1 = 2'h0;
    localparam logic [1:0] SPD_GEN2 = 2'h1;
    localparam logic [1:0] SPD_GEN3 = 2'h2;
    // reset values
    localparam logic [7:0] LANE_MASK_RST = 8'h00;

    typedef enum logic [3:0] {
        LWF_DOWN   = 4'h1,
        LWF_UP     = 4'h2,
        LWF_RECOV  = 4'h4,
        LWF_FAILED = 4'h8
    } lwf_link_t;

    typedef enum logic [2:0] {
        LWF_TO_IDLE = 3'h1,
        LWF_TO_REQ  = 3'h2,
        LWF_TO_DONE = 3'h4
    } lwf_turnoff_t;

    typedef enum logic [2:0] {
        LWF_AP_RUN  = 3'h1,
        LWF_AP_STOP = 3'h2,
        LWF_AP_OFF  = 3'h4
    } lwf_app_t;
endpackage : lwf_pkg
`default_nettype wire

/* pkg/lwf_if.sv */
/*
 * Carrier between the port (device end) and the link partner plus user
 * application (other end). Single clock domain, no tristate.
 */
`default_nettype none
interface lwf_if (
    input wire logic clock_i,
    input wire logic reset_i
);
    // link side
    logic [3:0] partner_width;   // partner advertised width
    logic [1:0] partner_speed;   // partner max speed
    logic       partner_reversed;
    logic       partner_lane0_ok; // partner lane 0 connected
    logic       turnoff_msg;     // one-cycle pulse: turnoff broadcast
    logic       turnoff_ack_msg; // one-cycle pulse: ack back upstream
    // application side
    logic       turnoff_notice;  // request flag to application
    logic       turnoff_consent; // application consent level

    modport dev (
        input  clock_i, reset_i, partner_width, partner_speed,
               partner_reversed, partner_lane0_ok, turnoff_msg,
               turnoff_consent,
        output turnoff_ack_msg, turnoff_notice
    );
    modport far (
        input  clock_i, reset_i, turnoff_ack_msg, turnoff_notice,
        output partner_width, partner_speed, partner_reversed,
               partner_lane0_ok, turnoff_msg, turnoff_consent
    );
endinterface : lwf_if
`default_nettype wire

/* src/lwf_width_sel.sv */
/*
 * Combinational width chooser: widest power-of-two contiguous lane set
 * from lane 0 within a cap and a mask of working lanes.
 * Assumes the caller registers the result.
 */
`default_nettype none
module lwf_width_sel (
    input  wire logic [3:0] cap_i,
    input  wire logic [7:0] good_i,
    output logic      [3:0] width_o
);
    always_comb begin
        width_o = lwf_pkg::WID_NONE;
        if (good_i[0]) begin
            width_o = lwf_pkg::WID_X1;
            if (cap_i >= lwf_pkg::WID_X2 && &good_i[1:0]) begin
                width_o = lwf_pkg::WID_X2;
            end
            if (cap_i >= lwf_pkg::WID_X4 && &good_i[3:0]) begin
                width_o = lwf_pkg::WID_X4;
            end
            if (cap_i >= lwf_pkg::WID_X8 && &good_i[7:0]) begin
                width_o = lwf_pkg::WID_X8;
            end
        end
    end
endmodule : lwf_width_sel
`default_nettype wire

/* src/lwf_port.sv */
/*
 * Device end: lane-width training, downshift, fault recovery without
 * re-widening, reversal support check, speed fallback and the turnoff
 * handshake toward the user application.
 * Assumes the far end drives the link fields synchronously to clock_i.
 * Clock and reset arrive through the carrier's dev modport.
 * Lane health and partner fields are levels; a lost width comes back
 * only through link_retrain_i. All outputs are registered, and the
 * turnoff handshake runs once per reset.
 */
`default_nettype none
module lwf_port #(
    parameter logic [3:0] OWN_WIDTH = 4'h8,
    parameter logic [1:0] OWN_SPEED = 2'h2
) (
    lwf_if.dev              link,
    input  wire logic [7:0] lane_ok_i,     // per-lane health
    input  wire logic       link_retrain_i, // full link-down restart
    output logic      [3:0] width_o,
    output logic      [1:0] speed_o,
    output logic      [7:0] lane_active_o,
    output logic            link_up_o,
    output logic            link_failed_o,
    output logic            reversed_o
);
    lwf_pkg::lwf_link_t    link_q, link_d;
    lwf_pkg::lwf_turnoff_t to_q, to_d;
    logic [3:0] width_q, width_d, cap_q, cap_d, sel_w, neg_w;
    logic [1:0] speed_q, speed_d;
    logic [7:0] act_q, act_d;
    logic       rev_q, rev_d, notice_q, notice_d, ack_q, ack_d;
    logic       up_q, up_d, fail_q, fail_d;

    // smaller of both advertised widths
    assign neg_w = (link.partner_width < OWN_WIDTH) ?
                   link.partner_width : OWN_WIDTH;

    lwf_width_sel u_sel (
        .cap_i   (cap_q),
        .good_i  (lane_ok_i),
        .width_o (sel_w)
    );

    always_comb begin
        link_d  = link_q;
        width_d = width_q;
        cap_d   = cap_q;
        speed_d = speed_q;
        rev_d   = rev_q;
        case (link_q)
            lwf_pkg::LWF_DOWN: begin
                cap_d = neg_w;
                speed_d = (link.partner_speed < OWN_SPEED) ?
                          link.partner_speed : OWN_SPEED;
                rev_d = link.partner_reversed;
                if (link.partner_reversed && neg_w != OWN_WIDTH) begin
                    link_d  = lwf_pkg::LWF_FAILED;
                    width_d = lwf_pkg::WID_NONE;
                end else if (!link.partner_lane0_ok) begin
                    link_d  = lwf_pkg::LWF_FAILED;
                    width_d = lwf_pkg::WID_NONE;
                end else if (neg_w != lwf_pkg::WID_NONE) begin
                    link_d = lwf_pkg::LWF_RECOV;
                end
            end
            lwf_pkg::LWF_RECOV: begin
                // train to widest viable set under current cap
                width_d = sel_w;
                cap_d   = sel_w;
                // a narrowed width never keeps reversal
                if (sel_w != OWN_WIDTH) begin
                    rev_d = 1'b0;
                end
                if (sel_w == lwf_pkg::WID_NONE) begin
                    link_d = lwf_pkg::LWF_FAILED;
                end else begin
                    link_d = lwf_pkg::LWF_UP;
                end
            end
            lwf_pkg::LWF_UP: begin
                if (!lane_ok_i[0]) begin
                    link_d  = lwf_pkg::LWF_FAILED;
                    width_d = lwf_pkg::WID_NONE;
                end else if (sel_w != width_q) begin
                    // only narrower is possible since cap tracks width
                    link_d = lwf_pkg::LWF_RECOV;
                    rev_d  = 1'b0;
                end
            end
            lwf_pkg::LWF_FAILED: begin
                width_d = lwf_pkg::WID_NONE;
            end
            default: begin
                link_d = lwf_pkg::LWF_DOWN;
            end
        endcase
        if (link_retrain_i) begin
            link_d  = lwf_pkg::LWF_DOWN;
            width_d = lwf_pkg::WID_NONE;
            rev_d   = 1'b0;
        end
    end

    // lane enable map, contiguous from lane 0
    for (genvar g = 0; g < lwf_pkg::LANES_MAX; g++) begin : g_lane
        assign act_d[g] = (g < int'(width_d));
    end

    always_comb begin
        up_d   = (link_d == lwf_pkg::LWF_UP);
        fail_d = (link_d == lwf_pkg::LWF_FAILED);
    end

    always_ff @(posedge link.clock_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            link_q  <= lwf_pkg::LWF_DOWN;
            width_q <= lwf_pkg::WID_NONE;
            cap_q   <= lwf_pkg::WID_NONE;
            speed_q <= lwf_pkg::SPD_GEN1;
            rev_q   <= 1'b0;
            act_q   <= lwf_pkg::LANE_MASK_RST;
            up_q    <= 1'b0;
            fail_q  <= 1'b0;
        end else begin
            link_q  <= link_d;
            width_q <= width_d;
            cap_q   <= cap_d;
            speed_q <= speed_d;
            rev_q   <= rev_d;
            act_q   <= act_d;
            up_q    <= up_d;
            fail_q  <= fail_d;
        end
    end

    // turnoff handshake
    always_comb begin
        to_d     = to_q;
        notice_d = notice_q;
        ack_d    = 1'b0;
        case (to_q)
            lwf_pkg::LWF_TO_IDLE: begin
                if (link.turnoff_msg) begin
                    to_d     = lwf_pkg::LWF_TO_REQ;
                    notice_d = 1'b1;
                end
            end
            lwf_pkg::LWF_TO_REQ: begin
                if (link.turnoff_consent) begin
                    to_d     = lwf_pkg::LWF_TO_DONE;
                    notice_d = 1'b0;
                    ack_d    = 1'b1;
                end
            end
            lwf_pkg::LWF_TO_DONE: begin
                // stays here until reset: power is about to go
            end
            default: begin
                to_d     = lwf_pkg::LWF_TO_IDLE;
                notice_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge link.clock_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            to_q     <= lwf_pkg::LWF_TO_IDLE;
            notice_q <= 1'b0;
            ack_q    <= 1'b0;
        end else begin
            to_q     <= to_d;
            notice_q <= notice_d;
            ack_q    <= ack_d;
        end
    end

    assign link.turnoff_notice  = notice_q;
    assign link.turnoff_ack_msg = ack_q;
    // clock_i is the fixed user clock; width changes never touch it
    assign width_o       = width_q;
    assign speed_o       = speed_q;
    assign lane_active_o = act_q;
    assign link_up_o     = up_q;
    assign link_failed_o = fail_q;
    assign reversed_o    = rev_q;
endmodule : lwf_port
`default_nettype wire

/* src/lwf_partner.sv */
/*
 * Other end: link partner advertising its width and speed, sending the
 * turnoff broadcast on request, and the user application that drains
 * traffic and then consents to power removal.
 * Assumes the device end shares clock_i.
 */
`default_nettype none
module lwf_partner (
    lwf_if.far              link,
    input  wire logic [3:0] adv_width_i,
    input  wire logic [1:0] adv_speed_i,
    input  wire logic       reversed_i,
    input  wire logic       lane0_ok_i,
    input  wire logic       power_off_req_i, // pulse: start power-down
    input  wire logic       pkt_busy_i,      // packet in progress
    output logic            pkt_allow_o,     // new packets permitted
    output logic            acked_o          // acknowledge received
);
    lwf_pkg::lwf_app_t ap_q, ap_d;
    logic msg_q, msg_d, cons_q, cons_d, ackd_q, ackd_d;

    always_comb begin
        ap_d   = ap_q;
        msg_d  = 1'b0;
        cons_d = cons_q;
        ackd_d = ackd_q | link.turnoff_ack_msg;
        if (power_off_req_i && ap_q == lwf_pkg::LWF_AP_RUN) begin
            msg_d = 1'b1;
        end
        case (ap_q)
            lwf_pkg::LWF_AP_RUN: begin
                if (link.turnoff_notice) begin
                    ap_d = lwf_pkg::LWF_AP_STOP;
                end
            end
            lwf_pkg::LWF_AP_STOP: begin
                if (!pkt_busy_i) begin
                    ap_d   = lwf_pkg::LWF_AP_OFF;
                    cons_d = 1'b1;
                end
            end
            lwf_pkg::LWF_AP_OFF: begin
                cons_d = 1'b1;
            end
            default: begin
                ap_d = lwf_pkg::LWF_AP_RUN;
            end
        endcase
    end

    always_ff @(posedge link.clock_i or posedge link.reset_i) begin
        if (link.reset_i) begin
            ap_q   <= lwf_pkg::LWF_AP_RUN;
            msg_q  <= 1'b0;
            cons_q <= 1'b0;
            ackd_q <= 1'b0;
        end else begin
            ap_q   <= ap_d;
            msg_q  <= msg_d;
            cons_q <= cons_d;
            ackd_q <= ackd_d;
        end
    end

    assign link.partner_width    = adv_width_i;
    assign link.partner_speed    = adv_speed_i;
    assign link.partner_reversed = reversed_i;
    assign link.partner_lane0_ok = lane0_ok_i;
    assign link.turnoff_msg      = msg_q;
    assign link.turnoff_consent  = cons_q;
    assign pkt_allow_o = (ap_q == lwf_pkg::LWF_AP_RUN);
    assign acked_o     = ackd_q;
endmodule : lwf_partner
`default_nettype wire

/* dv/lwf_asserts.sv */
/*
 * Checker for the turnoff handshake on the carrier between the ends.
 * Assumes one clock and an asynchronous active-high reset.
 */
`default_nettype none
module lwf_asserts (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic turnoff_msg,
    input wire logic turnoff_ack_msg,
    input wire logic turnoff_notice,
    input wire logic turnoff_consent
);
    timeunit 1ns;
    timeprecision 1ps;

    logic msg_seen_q;
    logic msg_seen_d;

    // only the first broadcast after reset is acted upon
    always_comb begin
        msg_seen_d = msg_seen_q | turnoff_msg;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            msg_seen_q <= 1'b0;
        end else begin
            msg_seen_q <= msg_seen_d;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    a_notice_on_msg: assert property (
        turnoff_msg && !msg_seen_q |=> turnoff_notice)
        else $error("notice not raised after turnoff message");
    a_notice_cause: assert property (
        $rose(turnoff_notice) |-> $past(turnoff_msg))
        else $error("notice raised without a turnoff message");
    a_notice_holds: assert property (
        turnoff_notice && !turnoff_consent |=> turnoff_notice)
        else $error("notice dropped before consent");
    a_ack_on_consent: assert property (
        turnoff_notice && turnoff_consent
        |=> turnoff_ack_msg && !turnoff_notice)
        else $error("no acknowledge after consent");
    a_ack_cause: assert property (
        $rose(turnoff_ack_msg)
        |-> $past(turnoff_consent) && $past(turnoff_notice))
        else $error("acknowledge without consent");
    a_ack_single: assert property (
        turnoff_ack_msg |=> !turnoff_ack_msg [*4])
        else $error("acknowledge longer than one pulse");
    a_consent_after: assert property (
        $rose(turnoff_consent) |-> turnoff_notice)
        else $error("consent without notice");
    a_consent_sticky: assert property (
        turnoff_consent |=> turnoff_consent)
        else $error("consent withdrawn");
endmodule : lwf_asserts
`default_nettype wire

/* dv/link_width_fallback_and_turnoff_tb_top.sv */
/*
 * Testbench joining an eight-lane port to its partner: width training,
 * faults, reversal, speed and the turnoff handshake.
 * Assumes the design files and lwf_pkg are compiled first.
 */
`default_nettype none
`define CHK(nm, e, g) \
    begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module link_width_fallback_and_turnoff_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [7:0] lane_ok = 8'hff;
    logic       retrain = 1'b0;
    logic [3:0] adv_w   = lwf_pkg::WID_X8;
    logic [1:0] adv_s   = lwf_pkg::SPD_GEN3;
    logic       rev     = 1'b0;
    logic       ok0     = 1'b1;
    logic       off_req = 1'b0;
    logic       busy    = 1'b1;
    logic [3:0] width;
    logic [1:0] speed;
    logic [7:0] active;
    logic       up;
    logic       failed;
    logic       rev_o;
    logic       allow;
    logic       acked;
    int         failures = 0;
    int         n_checks = 0;

    always #4 clock_i = ~clock_i;

    lwf_if lwf_link (.clock_i(clock_i), .reset_i(reset_i));

    lwf_port #(
        .OWN_WIDTH(lwf_pkg::WID_X8),
        .OWN_SPEED(lwf_pkg::SPD_GEN3)
    ) u_lwf_port (
        .link          (lwf_link),
        .lane_ok_i     (lane_ok),
        .link_retrain_i(retrain),
        .width_o       (width),
        .speed_o       (speed),
        .lane_active_o (active),
        .link_up_o     (up),
        .link_failed_o (failed),
        .reversed_o    (rev_o)
    );

    lwf_partner u_lwf_partner (
        .link           (lwf_link),
        .adv_width_i    (adv_w),
        .adv_speed_i    (adv_s),
        .reversed_i     (rev),
        .lane0_ok_i     (ok0),
        .power_off_req_i(off_req),
        .pkt_busy_i     (busy),
        .pkt_allow_o    (allow),
        .acked_o        (acked)
    );

    // x2 and x4 ports beside the x8 one, seeing the same partner settings
    for (genvar g = 0; g < 2; g++) begin : g_narrow
        logic [3:0] width_n;
        lwf_if lwf_link_n (.clock_i(clock_i), .reset_i(reset_i));
        assign lwf_link_n.partner_width    = adv_w;
        assign lwf_link_n.partner_speed    = adv_s;
        assign lwf_link_n.partner_reversed = rev;
        assign lwf_link_n.partner_lane0_ok = ok0;
        assign lwf_link_n.turnoff_msg      = 1'b0;
        assign lwf_link_n.turnoff_consent  = 1'b0;
        lwf_port #(
            .OWN_WIDTH(4'(2 << g)),
            .OWN_SPEED(lwf_pkg::SPD_GEN3)
        ) u_lwf_port (
            .link          (lwf_link_n),
            .lane_ok_i     (lane_ok),
            .link_retrain_i(retrain),
            .width_o       (width_n),
            .speed_o       (),
            .lane_active_o (),
            .link_up_o     (),
            .link_failed_o (),
            .reversed_o    ()
        );
    end

    lwf_asserts u_lwf_asserts (
        .clock_i        (clock_i),
        .reset_i        (reset_i),
        .turnoff_msg    (lwf_link.turnoff_msg),
        .turnoff_ack_msg(lwf_link.turnoff_ack_msg),
        .turnoff_notice (lwf_link.turnoff_notice),
        .turnoff_consent(lwf_link.turnoff_consent)
    );

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step

    task automatic wait_link();
        int i;
        for (i = 0; i < 16 && up !== 1'b1 && failed !== 1'b1; i++) begin
            step(1);
        end
        if (i == 16) begin
            failures++;
            test_done();
        end
    endtask : wait_link

    // full link-down restart with new partner settings
    task automatic train(input logic [3:0] w, input logic r,
                         input logic z,
                         input logic [1:0] s = lwf_pkg::SPD_GEN3);
        adv_w = w;
        rev = r;
        ok0 = z;
        adv_s = s;
        retrain = 1'b1;
        step(1);
        retrain = 1'b0;
        wait_link();
    endtask : train

    task automatic chk_up(input logic [3:0] w, input logic r);
        `CHK("link up", 1'b1, up)
        `CHK("width", w, width)
        `CHK("lanes", 8'((9'h1 << w) - 9'h1), active)
        `CHK("reversed", r, rev_o)
    endtask : chk_up

    initial begin
        step(5);
        reset_i = 1'b0;
        wait_link();
        chk_up(lwf_pkg::WID_X8, 1'b0);
        for (int k = 0; k < 4; k++) begin
            train(4'(1 << k), 1'b0, 1'b1, 2'(k % 3));
            chk_up(4'(1 << k), 1'b0);
            `CHK("speed", 2'(k % 3), speed)
            `CHK("x2", (k > 0) ? 4'h2 : 4'h1, g_narrow[0].width_n)
            `CHK("x4", (k > 1) ? 4'h4 : 4'(1 << k), g_narrow[1].width_n)
        end
        train(lwf_pkg::WID_X8, 1'b1, 1'b1);
        chk_up(lwf_pkg::WID_X8, 1'b1);
        train(lwf_pkg::WID_X4, 1'b1, 1'b1);
        `CHK("reversed downshift", 1'b1, failed)
        train(lwf_pkg::WID_X8, 1'b0, 1'b0);
        `CHK("partner lane0 off", 1'b1, failed)
        train(lwf_pkg::WID_X8, 1'b0, 1'b1);
        // lane 6, then lane 1, then lane 0 lost
        lane_ok = 8'hbf;
        step(3);
        chk_up(lwf_pkg::WID_X4, 1'b0);
        lane_ok = 8'hff;
        step(3);
        chk_up(lwf_pkg::WID_X4, 1'b0);
        lane_ok = 8'hfd;
        step(3);
        chk_up(lwf_pkg::WID_X1, 1'b0);
        lane_ok = 8'hfe;
        step(3);
        `CHK("lane0 lost", 1'b1, failed)
        lane_ok = 8'hff;
        step(3);
        `CHK("stays down", 1'b0, up)
        train(lwf_pkg::WID_X8, 1'b0, 1'b1);
        chk_up(lwf_pkg::WID_X8, 1'b0);
        // power-down while a packet is still running
        off_req = 1'b1;
        step(1);
        off_req = 1'b0;
        step(5);
        `CHK("notice", 1'b1, lwf_link.turnoff_notice)
        `CHK("new packets", 1'b0, allow)
        `CHK("early ack", 1'b0, acked)
        busy = 1'b0;
        for (int i = 0; i < 16 && acked !== 1'b1; i++) begin
            step(1);
        end
        `CHK("acked", 1'b1, acked)
        `CHK("notice off", 1'b0, lwf_link.turnoff_notice)
        `CHK("stay stopped", 1'b0, allow)
        test_done();
    end
endmodule : link_width_fallback_and_turnoff_tb_top
`default_nettype wire
